// ===== common/dmau_map.vh
// Purpose: address map, field positions and constants of the data memory addressing unit
// Assumes: 8-bit data memory, six sectors of 256 locations, 11-bit extended operand
// Notes:   all widths fixed; included by bare name
`ifndef DMAU_MAP_VH
`define DMAU_MAP_VH

`define DMAU_DW            8
`define DMAU_AW            11
`define DMAU_SEC_W         3
`define DMAU_LOC_W         8
`define DMAU_SEC_HI        10
`define DMAU_SEC_LO        8
`define DMAU_LOC_HI        7
`define DMAU_LOC_LO        0
`define DMAU_NUM_SEC       6
`define DMAU_GP_DEPTH      768
`define DMAU_GP_IDX_W      10
`define DMAU_LCD_DEPTH     48
`define DMAU_LCD_IDX_W     6

`define DMAU_ZERO8         8'h00
`define DMAU_SEC0          3'h0
`define DMAU_SEC1          3'h1
`define DMAU_SEC_LCD       3'h4
`define DMAU_SEC_LAST      3'h5
`define DMAU_GP_BASE       8'h80
`define DMAU_LCD_LAST      8'h2F
`define DMAU_SFR_LAST      7'h7F

`define DMAU_OFS_PORT0     8'h00
`define DMAU_OFS_PTR0      8'h01
`define DMAU_OFS_PORT1     8'h02
`define DMAU_OFS_PTR1L     8'h03
`define DMAU_OFS_PTR1H     8'h04
`define DMAU_OFS_PORT2     8'h0C
`define DMAU_OFS_PTR2L     8'h0D
`define DMAU_OFS_PTR2H     8'h0E

`define DMAU_PTR_RST       8'h00

`define DMAU_MODE_DIR      2'h0
`define DMAU_MODE_EXT      2'h1

`define DMAU_OP_NONE       2'h0
`define DMAU_OP_INC        2'h1
`define DMAU_OP_DEC        2'h2

`endif

// ===== hdl/dmau_gp_ram.v
// Purpose: general purpose data RAM, one byte per location with bit set/clear
// Assumes: single write port, asynchronous read
// Notes:   array declared here; contents are not reset
`default_nettype none
`include "dmau_map.vh"

module dmau_gp_ram (
    input  wire                          clk,     // core clock
    input  wire                          we,      // byte write strobe
    input  wire                          bit_op,  // bit set/clear strobe
    input  wire                          bit_val, // value for the bit
    input  wire [2:0]                    bit_sel, // bit index
    input  wire [`DMAU_GP_IDX_W-1:0]     idx,     // location index
    input  wire [`DMAU_DW-1:0]           wdata,   // write byte
    output wire [`DMAU_DW-1:0]           rdata    // read byte
);

    reg [`DMAU_DW-1:0] mem [0:`DMAU_GP_DEPTH-1]; // byte wide store
    wire [`DMAU_DW-1:0] cur;

    assign cur   = mem[idx];
    assign rdata = cur;

    // byte write or single bit update with the rest kept
    always @(posedge clk) begin
        if (we) begin
            mem[idx] <= wdata;
        end else if (bit_op) begin
            mem[idx] <= (cur & ~({{(`DMAU_DW-1){1'b0}}, 1'b1} << bit_sel)) |
                        ({{(`DMAU_DW-1){1'b0}}, bit_val} << bit_sel);
        end
    end

endmodule
`default_nettype wire

// ===== hdl/dmau_lcd_ram.v
// Purpose: display data memory window in sector 4
// Assumes: display side reads through its own port
// Notes:   contents are not reset
`default_nettype none
`include "dmau_map.vh"

module dmau_lcd_ram (
    input  wire                          clk,      // core clock
    input  wire                          we,       // write strobe
    input  wire [`DMAU_LCD_IDX_W-1:0]    idx,      // core side index
    input  wire [`DMAU_DW-1:0]           wdata,    // write byte
    output wire [`DMAU_DW-1:0]           rdata,    // core side byte
    input  wire [`DMAU_LCD_IDX_W-1:0]    disp_idx, // display side index
    output reg  [`DMAU_DW-1:0]           disp_q    // display side byte
);

    reg [`DMAU_DW-1:0] mem [0:`DMAU_LCD_DEPTH-1];

    assign rdata = mem[idx];

    // core writes land in the one array; the display byte is registered, so a write shows there one edge later
    always @(posedge clk) begin
        if (we) begin
            mem[idx] <= wdata;
        end
        disp_q <= mem[disp_idx];
    end

endmodule
`default_nettype wire

// ===== hdl/dmau_top.v
// Purpose: data memory address formation, pointer registers and region decode
// Assumes: core presents one access per cycle; reads complete same cycle
// Notes:   special registers other than pointers live outside, reached via sfr_* ports
`default_nettype none
`include "dmau_map.vh"

module dmau_top (
    input  wire                          clk,          // core clock, 125 MHz
    input  wire                          arst_n,       // async reset, active low
    input  wire                          acc_rd,       // core read strobe
    input  wire                          acc_wr,       // core byte write strobe
    input  wire                          acc_bit,      // core bit set/clear strobe
    input  wire                          acc_bit_val,  // bit value for set/clear
    input  wire [2:0]                    acc_bit_sel,  // bit index
    input  wire [1:0]                    acc_ptr_op,   // pointer step on access location
    input  wire [1:0]                    acc_mode,     // standard or extended address
    input  wire [`DMAU_AW-1:0]           acc_addr,     // operand address
    input  wire [`DMAU_DW-1:0]           acc_wdata,    // write byte
    output reg  [`DMAU_DW-1:0]           acc_rdata,    // read byte
    output wire [`DMAU_AW-1:0]           eff_addr,     // resolved sector and location
    output wire                          sfr_rd,       // external special register read
    output wire                          sfr_wr,       // external special register write
    output wire [`DMAU_AW-1:0]           sfr_addr,     // external special register address
    output wire [`DMAU_DW-1:0]           sfr_wdata,    // external special register data
    input  wire [`DMAU_DW-1:0]           sfr_rdata,    // external register read data
    input  wire                          sfr_present,  // location is implemented
    input  wire                          sfr_protect,  // location is read only
    input  wire [`DMAU_LCD_IDX_W-1:0]    lcd_idx,      // display scan index
    output wire [`DMAU_DW-1:0]           lcd_data,     // display scan byte
    output wire [`DMAU_DW-1:0]           ptr0_q_o,     // pointer_0 value
    output wire [`DMAU_DW-1:0]           ptr1_o,       // pointer_1_low value
    output wire [`DMAU_DW-1:0]           ptr2_o        // pointer_2_low value
);

    // pointer registers, held here since they steer address formation
    reg  [`DMAU_DW-1:0] pointer_0_q;
    reg  [`DMAU_DW-1:0] pointer_1_low_q;
    reg  [`DMAU_DW-1:0] pointer_1_high_q;
    reg  [`DMAU_DW-1:0] pointer_2_low_q;
    reg  [`DMAU_DW-1:0] pointer_2_high_q;

    // decoded first-level address
    wire                     is_ext;
    wire [`DMAU_SEC_W-1:0]   raw_sec;
    wire [`DMAU_LOC_W-1:0]   raw_loc;
    wire                     hit_port0;
    wire                     hit_port1;
    wire                     hit_port2;

    // resolved address
    reg  [`DMAU_SEC_W-1:0]   sec;
    reg  [`DMAU_LOC_W-1:0]   loc;
    wire                     via_port;

    // region decode
    wire                     sec_ok;
    wire                     in_gp;
    wire                     in_lcd;
    wire                     in_sfr;
    wire                     own_ptr;
    wire [`DMAU_GP_IDX_W-1:0] gp_idx;
    wire [`DMAU_DW-1:0]      gp_rdata;
    wire [`DMAU_DW-1:0]      lcd_rdata;
    reg  [`DMAU_DW-1:0]      own_rdata;
    wire [`DMAU_DW-1:0]      new_byte;
    wire                     wr_any;
    wire                     ptr_step;

    // extended operand: 11 bits, sector from 10..8, location from 7..0; no bank register
    assign is_ext  = (acc_mode == `DMAU_MODE_EXT);
    assign raw_sec = is_ext ? acc_addr[`DMAU_SEC_HI:`DMAU_SEC_LO] : `DMAU_SEC0;
    assign raw_loc = acc_addr[`DMAU_LOC_HI:`DMAU_LOC_LO];

    // access port locations live in sector 0 only
    assign hit_port0 = (raw_sec == `DMAU_SEC0) && (raw_loc == `DMAU_OFS_PORT0);
    assign hit_port1 = (raw_sec == `DMAU_SEC0) && (raw_loc == `DMAU_OFS_PORT1);
    assign hit_port2 = (raw_sec == `DMAU_SEC0) && (raw_loc == `DMAU_OFS_PORT2);
    assign via_port  = hit_port0 | hit_port1 | hit_port2;

    // redirect through the paired pointer
    always @* begin
        sec = raw_sec;
        loc = raw_loc;
        if (hit_port0) begin
            sec = `DMAU_SEC0;
            loc = pointer_0_q;
        end else if (hit_port1) begin
            sec = pointer_1_high_q[`DMAU_SEC_W-1:0];
            loc = pointer_1_low_q;
        end else if (hit_port2) begin
            sec = pointer_2_high_q[`DMAU_SEC_W-1:0];
            loc = pointer_2_low_q;
        end
    end

    assign eff_addr = {sec, loc};

    // region decode; a port reached through a pointer lands on itself and is empty
    assign sec_ok  = (sec <= `DMAU_SEC_LAST);
    assign in_gp   = sec_ok && (loc >= `DMAU_GP_BASE);
    assign in_lcd  = (sec == `DMAU_SEC_LCD) && (loc <= `DMAU_LCD_LAST);
    assign in_sfr  = sec_ok && !in_gp && !in_lcd && (loc[7] == 1'b0);
    assign own_ptr = (sec == `DMAU_SEC0) && ((loc == `DMAU_OFS_PTR0) ||
                     (loc == `DMAU_OFS_PTR1L) || (loc == `DMAU_OFS_PTR1H) ||
                     (loc == `DMAU_OFS_PTR2L) || (loc == `DMAU_OFS_PTR2H));
    wire land_port = (sec == `DMAU_SEC0) && ((loc == `DMAU_OFS_PORT0) ||
                     (loc == `DMAU_OFS_PORT1) || (loc == `DMAU_OFS_PORT2));

    // general RAM index: sector * 128 + low seven bits
    assign gp_idx = {sec[2:0], loc[6:0]};

    // new value for read-modify-write of pointers and external registers; the
    // base is the byte read this cycle so a bit op keeps the other seven bits
    assign new_byte = acc_bit ? ((acc_rdata & ~({{(`DMAU_DW-1){1'b0}}, 1'b1} << acc_bit_sel)) |
                      ({{(`DMAU_DW-1){1'b0}}, acc_bit_val} << acc_bit_sel)) : acc_wdata;
    assign wr_any   = acc_wr | acc_bit;
    assign ptr_step = (acc_ptr_op != `DMAU_OP_NONE);

    dmau_gp_ram u_gp (
        .clk     (clk),
        .we      (acc_wr & in_gp),
        .bit_op  (acc_bit & in_gp),
        .bit_val (acc_bit_val),
        .bit_sel (acc_bit_sel),
        .idx     (gp_idx),
        .wdata   (acc_wdata),
        .rdata   (gp_rdata)
    );

    dmau_lcd_ram u_lcd (
        .clk      (clk),
        .we       (acc_wr & in_lcd),
        .idx      (loc[`DMAU_LCD_IDX_W-1:0]),
        .wdata    (acc_wdata),
        .rdata    (lcd_rdata),
        .disp_idx (lcd_idx),
        .disp_q   (lcd_data)
    );

    // own pointer read value
    always @* begin
        case (loc)
            `DMAU_OFS_PTR0:  own_rdata = pointer_0_q;
            `DMAU_OFS_PTR1L: own_rdata = pointer_1_low_q;
            `DMAU_OFS_PTR1H: own_rdata = pointer_1_high_q;
            `DMAU_OFS_PTR2L: own_rdata = pointer_2_low_q;
            `DMAU_OFS_PTR2H: own_rdata = pointer_2_high_q;
            default:         own_rdata = `DMAU_ZERO8;
        endcase
    end

    // external special registers: protected or absent ones take no write
    assign sfr_addr  = eff_addr;
    assign sfr_wdata = new_byte;
    assign sfr_rd    = acc_rd & in_sfr & !own_ptr & !land_port;
    assign sfr_wr    = wr_any & in_sfr & !own_ptr & !land_port & sfr_present & !sfr_protect;

    // read mux; ports and unused locations read as zero
    always @* begin
        acc_rdata = `DMAU_ZERO8;
        if (land_port) begin
            acc_rdata = `DMAU_ZERO8;
        end else if (in_gp) begin
            acc_rdata = gp_rdata;
        end else if (in_lcd) begin
            acc_rdata = lcd_rdata;
        end else if (own_ptr) begin
            acc_rdata = own_rdata;
        end else if (in_sfr && sfr_present) begin
            acc_rdata = sfr_rdata;
        end else begin
            acc_rdata = `DMAU_ZERO8;
        end
    end

    // pointer updates: writes, bit ops and low-byte-only stepping
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pointer_0_q      <= `DMAU_PTR_RST;
            pointer_1_low_q  <= `DMAU_PTR_RST;
            pointer_1_high_q <= `DMAU_PTR_RST;
            pointer_2_low_q  <= `DMAU_PTR_RST;
            pointer_2_high_q <= `DMAU_PTR_RST;
        end else if (own_ptr && !land_port) begin
            if (wr_any) begin
                case (loc)
                    `DMAU_OFS_PTR0:  pointer_0_q      <= new_byte;
                    `DMAU_OFS_PTR1L: pointer_1_low_q  <= new_byte;
                    `DMAU_OFS_PTR1H: pointer_1_high_q <= new_byte;
                    `DMAU_OFS_PTR2L: pointer_2_low_q  <= new_byte;
                    `DMAU_OFS_PTR2H: pointer_2_high_q <= new_byte;
                    default:         pointer_0_q      <= pointer_0_q;
                endcase
            end else if (ptr_step) begin
                case (loc)
                    `DMAU_OFS_PTR0:  pointer_0_q <= (acc_ptr_op == `DMAU_OP_INC) ?
                                     pointer_0_q + 8'h01 : pointer_0_q - 8'h01;
                    `DMAU_OFS_PTR1L: pointer_1_low_q <= (acc_ptr_op == `DMAU_OP_INC) ?
                                     pointer_1_low_q + 8'h01 : pointer_1_low_q - 8'h01;
                    `DMAU_OFS_PTR2L: pointer_2_low_q <= (acc_ptr_op == `DMAU_OP_INC) ?
                                     pointer_2_low_q + 8'h01 : pointer_2_low_q - 8'h01;
                    default:         pointer_0_q <= pointer_0_q;
                endcase
            end
        end
    end

    assign ptr0_q_o = pointer_0_q;
    assign ptr1_o   = pointer_1_low_q;
    assign ptr2_o   = pointer_2_low_q;

endmodule
`default_nettype wire

// ===== verification/dmau_sfr_model.sv
// Purpose: far-side special register block answering the addressing unit
// Assumes: one writable byte at 020H, one read-only byte at 021H, rest absent
// Notes:   stores on any strobe, so refusing protected writes is the unit's job
`default_nettype none
`include "dmau_map.vh"
module dmau_sfr_model (
    input  wire logic                clk,         // core clock
    input  wire logic                sfr_wr,      // write strobe
    input  wire logic [`DMAU_AW-1:0] sfr_addr,    // location
    input  wire logic [`DMAU_DW-1:0] sfr_wdata,   // write byte
    output logic      [`DMAU_DW-1:0] sfr_rdata,   // read byte
    output logic                     sfr_present, // location implemented
    output logic                     sfr_protect  // location read only
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rw_q = 8'h00;
    logic [7:0] ro_q = 8'h5A;
    logic [7:0] junk_q = 8'h00;
    // storage and a moving value for absent locations
    always @(posedge clk) begin
        junk_q <= junk_q + 8'h5B;
        if (sfr_wr && sfr_addr == 11'h020) rw_q <= sfr_wdata;
        if (sfr_wr && sfr_addr == 11'h021) ro_q <= sfr_wdata;
    end
    // decode of present, protected and read data
    always_comb begin
        sfr_present = (sfr_addr == 11'h020) || (sfr_addr == 11'h021);
        sfr_protect = (sfr_addr == 11'h021);
        sfr_rdata = (sfr_addr == 11'h020) ? rw_q : (sfr_addr == 11'h021) ? ro_q : junk_q;
    end
endmodule
`default_nettype wire

// ===== verification/dmau_top_properties.sv
// Purpose: port-level checks of address formation and region decode
// Assumes: single clock domain, asynchronous active-low reset
// Notes:   bound to the top module after the checker
`default_nettype none
`include "dmau_map.vh"
module dmau_chk (
    input wire logic                clk,         // core clock
    input wire logic                arst_n,      // async reset, active low
    input wire logic                acc_rd,      // read strobe
    input wire logic                acc_wr,      // write strobe
    input wire logic                acc_bit,     // bit strobe
    input wire logic [1:0]          acc_ptr_op,  // pointer step
    input wire logic [1:0]          acc_mode,    // address mode
    input wire logic [`DMAU_AW-1:0] acc_addr,    // operand address
    input wire logic [`DMAU_DW-1:0] acc_wdata,   // write byte
    input wire logic [`DMAU_DW-1:0] acc_rdata,   // read byte
    input wire logic [`DMAU_AW-1:0] eff_addr,    // resolved address
    input wire logic                sfr_rd,      // register read
    input wire logic                sfr_wr,      // register write
    input wire logic [`DMAU_AW-1:0] sfr_addr,    // register address
    input wire logic                sfr_present, // implemented
    input wire logic                sfr_protect, // read only
    input wire logic [`DMAU_DW-1:0] ptr0_q_o,    // pointer_0
    input wire logic [`DMAU_DW-1:0] ptr1_o,      // pointer_1_low
    input wire logic [`DMAU_DW-1:0] ptr2_o       // pointer_2_low
);
    default clocking dmau_cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic is_port;
    // operand low byte names an indirect port
    assign is_port = acc_addr[7:0] == 8'h00 || acc_addr[7:0] == 8'h02 || acc_addr[7:0] == 8'h0C;
    sequence s_inc1;
        acc_ptr_op == `DMAU_OP_INC && acc_mode == `DMAU_MODE_DIR && acc_addr[7:0] == 8'h03 && !acc_wr && !acc_bit;
    endsequence
    sequence s_dec0;
        acc_ptr_op == `DMAU_OP_DEC && acc_mode == `DMAU_MODE_DIR && acc_addr[7:0] == 8'h01 && !acc_wr && !acc_bit;
    endsequence
    a_std_direct: assert property (acc_mode == `DMAU_MODE_DIR && !is_port |-> eff_addr == {3'h0, acc_addr[7:0]})
        else $error("standard address not in sector zero");
    a_ext_decode: assert property (acc_mode == `DMAU_MODE_EXT && acc_addr[10:8] <= 3'h5
        && !(acc_addr[10:8] == 3'h0 && is_port) |-> eff_addr == acc_addr) else $error("extended address misdecoded");
    a_port0_sector: assert property (acc_mode == `DMAU_MODE_DIR && acc_addr[7:0] == 8'h00
        |-> eff_addr == {3'h0, ptr0_q_o}) else $error("port zero left sector zero");
    a_port1_low: assert property (acc_mode == `DMAU_MODE_DIR && acc_addr[7:0] == 8'h02
        |-> eff_addr[7:0] == ptr1_o) else $error("port one location wrong");
    a_port2_low: assert property (acc_mode == `DMAU_MODE_DIR && acc_addr[7:0] == 8'h0C
        |-> eff_addr[7:0] == ptr2_o) else $error("port two location wrong");
    a_unused_zero: assert property (acc_rd && sfr_rd && !sfr_present |-> acc_rdata == 8'h00)
        else $error("unused location read nonzero");
    a_protect_write: assert property (sfr_wr |-> !sfr_protect) else $error("write reached protected register");
    a_sfr_region: assert property (sfr_wr |-> sfr_addr == eff_addr && sfr_addr[7] == 1'b0)
        else $error("register write outside special region");
    a_port_nostore: assert property (sfr_wr && sfr_addr[10:8] == 3'h0 |-> sfr_addr[7:0] != 8'h00
        && sfr_addr[7:0] != 8'h02 && sfr_addr[7:0] != 8'h0C) else $error("port location stored");
    a_ptr1_step: assert property (s_inc1 |=> ptr1_o == $past(ptr1_o) + 8'h01) else $error("low pointer step wrong");
    a_ptr0_dec: assert property (s_dec0 |=> ptr0_q_o == $past(ptr0_q_o) - 8'h01) else $error("pointer_0 step wrong");
endmodule
bind dmau_top dmau_chk dmau_chk_i (.clk(clk), .arst_n(arst_n), .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_bit(acc_bit),
    .acc_ptr_op(acc_ptr_op), .acc_mode(acc_mode), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
    .eff_addr(eff_addr), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_present(sfr_present),
    .sfr_protect(sfr_protect), .ptr0_q_o(ptr0_q_o), .ptr1_o(ptr1_o), .ptr2_o(ptr2_o));
`default_nettype wire

// ===== verification/testbench.sv
// Purpose: self-checking bench of the data memory addressing unit
// Assumes: accesses driven at rising edge, reads settle in the same cycle
// Notes:   table rows write then read back; hand tests cover ports and steps
`default_nettype none
`include "dmau_map.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct { logic [1:0] m; logic [10:0] a; logic [7:0] d; logic [10:0] e; } dmau_row_t;
    logic clk = 1'b0, arst_n = 1'b0, acc_rd = 1'b0, acc_wr = 1'b0, acc_bit = 1'b0, acc_bit_val = 1'b0;
    logic [2:0] acc_bit_sel = 3'h0;
    logic [1:0] acc_ptr_op = 2'h0, acc_mode = 2'h0;
    logic [10:0] acc_addr = 11'h000, eff_addr, sfr_addr;
    logic [7:0] acc_wdata = 8'h00, acc_rdata, sfr_wdata, sfr_rdata, lcd_data, ptr0_q_o, ptr1_o, ptr2_o;
    logic sfr_rd, sfr_wr, sfr_present, sfr_protect;
    logic [5:0] lcd_idx = 6'h00;
    int errors = 0, checks_done = 0;
    dmau_row_t rows [6] = '{'{2'h1, 11'h1F0, 8'h3C, 11'h1F0}, '{2'h1, 11'h5FF, 8'hC3, 11'h5FF},
        '{2'h1, 11'h080, 8'h11, 11'h080}, '{2'h0, 11'h0A0, 8'h22, 11'h0A0}, '{2'h0, 11'h001, 8'h85, 11'h001},
        '{2'h0, 11'h020, 8'h77, 11'h020}};
    dmau_top dmau_top_i (.clk(clk), .arst_n(arst_n), .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_bit(acc_bit),
        .acc_bit_val(acc_bit_val), .acc_bit_sel(acc_bit_sel), .acc_ptr_op(acc_ptr_op), .acc_mode(acc_mode),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .eff_addr(eff_addr), .sfr_rd(sfr_rd),
        .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sfr_present(sfr_present), .sfr_protect(sfr_protect), .lcd_idx(lcd_idx), .lcd_data(lcd_data),
        .ptr0_q_o(ptr0_q_o), .ptr1_o(ptr1_o), .ptr2_o(ptr2_o));
    dmau_sfr_model dmau_sfr_model_i (.clk(clk), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .sfr_present(sfr_present), .sfr_protect(sfr_protect));
    // clock at 8 ns period
    always #4 clk = ~clk;
    task automatic print_verdict;
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmp11(input string n, input logic [10:0] e, input logic [10:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // one access for one cycle: k 0 write, 1 bit op (d[3] value, d[2:0] index), 2 step up, 3 step down
    task automatic put(input logic [1:0] m, input logic [10:0] a, input logic [7:0] d, input int k);
        @(posedge clk);
        acc_rd <= 1'b0;
        acc_mode <= m;
        acc_addr <= a;
        acc_wdata <= d;
        acc_bit_val <= d[3];
        acc_bit_sel <= d[2:0];
        acc_wr <= (k == 0);
        acc_bit <= (k == 1);
        acc_ptr_op <= (k == 2) ? `DMAU_OP_INC : (k == 3) ? `DMAU_OP_DEC : `DMAU_OP_NONE;
        @(posedge clk);
        acc_wr <= 1'b0;
        acc_bit <= 1'b0;
        acc_ptr_op <= `DMAU_OP_NONE;
    endtask
    // read and compare data and resolved address
    task automatic look(input logic [1:0] m, input logic [10:0] a, input logic [7:0] d, input logic [10:0] e);
        @(posedge clk);
        acc_rd <= 1'b1;
        acc_mode <= m;
        acc_addr <= a;
        #2;
        cmp8("acc_rdata", d, acc_rdata);
        cmp11("eff_addr", e, eff_addr);
    endtask
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        print_verdict();
    end
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        #2;
        cmp8("ptr0_q_o", 8'h00, ptr0_q_o);
        cmp8("ptr1_o", 8'h00, ptr1_o);
        cmp8("ptr2_o", 8'h00, ptr2_o);
        foreach (rows[i]) begin
            put(rows[i].m, rows[i].a, rows[i].d, 0);
            look(rows[i].m, rows[i].a, rows[i].d, rows[i].e);
        end
        put(2'h0, 11'h003, 8'h90, 0);
        put(2'h0, 11'h004, 8'h02, 0);
        put(2'h0, 11'h002, 8'h5E, 0);
        look(2'h0, 11'h002, 8'h5E, 11'h290);
        look(2'h1, 11'h290, 8'h5E, 11'h290);
        put(2'h0, 11'h00D, 8'hC0, 0);
        put(2'h0, 11'h00E, 8'h05, 0);
        put(2'h0, 11'h00C, 8'h6B, 0);
        look(2'h0, 11'h00C, 8'h6B, 11'h5C0);
        look(2'h1, 11'h5C0, 8'h6B, 11'h5C0);
        put(2'h0, 11'h00D, 8'h00, 2);
        #2;
        cmp8("ptr2_o", 8'hC1, ptr2_o);
        put(2'h0, 11'h000, 8'h99, 0);
        look(2'h0, 11'h000, 8'h99, 11'h085);
        put(2'h0, 11'h001, 8'h00, 0);
        put(2'h0, 11'h000, 8'hFF, 0);
        look(2'h0, 11'h000, 8'h00, 11'h000);
        put(2'h0, 11'h030, 8'hFF, 0);
        look(2'h0, 11'h030, 8'h00, 11'h030);
        put(2'h0, 11'h021, 8'h00, 0);
        look(2'h0, 11'h021, 8'h5A, 11'h021);
        put(2'h1, 11'h0C0, 8'hA5, 0);
        put(2'h1, 11'h0C0, 8'h09, 1);
        put(2'h1, 11'h0C0, 8'h07, 1);
        look(2'h1, 11'h0C0, 8'h27, 11'h0C0);
        put(2'h0, 11'h003, 8'hFF, 0);
        put(2'h0, 11'h003, 8'h00, 2);
        look(2'h0, 11'h003, 8'h00, 11'h003);
        look(2'h0, 11'h004, 8'h02, 11'h004);
        cmp8("ptr1_o", 8'h00, ptr1_o);
        put(2'h0, 11'h001, 8'h00, 3);
        #2;
        cmp8("ptr0_q_o", 8'hFF, ptr0_q_o);
        put(2'h1, 11'h680, 8'h44, 0);
        look(2'h1, 11'h080, 8'h11, 11'h080);
        put(2'h1, 11'h410, 8'h3A, 0);
        lcd_idx <= 6'h10;
        repeat (2) @(posedge clk);
        #2;
        cmp8("lcd_data", 8'h3A, lcd_data);
        print_verdict();
    end
endmodule
`default_nettype wire
